// >>> common/prf_defines.vh
// constants used by the region freeze wrapper; its force-high cell uses none of them
`ifndef PRF_DEFINES_VH
`define PRF_DEFINES_VH

// number of reconfigurable regions behind this wrapper
`define PRF_NUM_REGIONS 2
// width of the region select used to pick the region being reconfigured
`define PRF_SEL_W 1

// boundary widths of one region
`define PRF_CTRL_W 4
`define PRF_DATA_W 16

// level forced onto a 4-bit control bus during freeze
`define PRF_CTRL_FROZEN 4'hf
// level forced onto a single non-global bit during freeze, clock included
`define PRF_BIT_FROZEN 1'b1
// safe inactive value for the active-high region outputs
`define PRF_OUT_SAFE 16'h0000
// value of the registered outputs after reset
`define PRF_OUT_RESET 16'h0000

// global network budget of one region
`define PRF_MAX_GLOBALS 6
// global nets used here: global clock and asynchronous clear
`define PRF_GLOBALS_USED 2

// clock period of clk in picoseconds (250 MHz)
`define PRF_CLK_PERIOD_PS 4000
// least time the new persona is held in its local reset after freeze drops
`define PRF_PERSONA_RESET_NS 64
// width of the persona reset counter
`define PRF_RST_CNT_W 5

// region state codes
`define PRF_ST_RUN 2'h0
`define PRF_ST_FROZEN 2'h1
`define PRF_ST_RESET 2'h2

`endif

// >>> logic/prf_force_high.v
// one freeze cell: forces a region input bundle high while frozen
module prf_force_high #(
  parameter W = 4
) (
  input wire freeze,
  input wire [W-1:0] src,
  output wire [W-1:0] dst
);

  // pure mux, no flop, so a local clock stays a clock when not frozen
  assign dst = freeze ? {W{1'b1}} : src;

endmodule

// >>> logic/prf_freeze_wrapper.v
// freeze wrapper for a set of partially reconfigurable regions
`include "prf_defines.vh"

// How it works
// - while frozen, every non-global region input is forced to all ones.
// - locally routed inputs count as non-global and are frozen high too.
// - global clock and global async clear pass straight into the region.
// - the local clock input is held at one while frozen, else follows source.
// - only the region selected for reconfiguration is frozen; others keep running.
// - region outputs may be clamped to a safe inactive zero while frozen.
// - region outputs seen by static logic are held during reconfiguration when the clamp is off.
// - at most six distinct global nets may enter one region.
// - global nets into a region carry only clocks and async clears.
// - an input fed globally in one persona is fed globally in every persona.
// - a shared global net keeps the same role in static and region logic.
module prf_freeze_wrapper (
  input wire clk,
  input wire rst,
  input wire freeze,
  input wire [`PRF_SEL_W-1:0] freeze_region_sel,
  input wire clamp_enable,
  input wire [`PRF_NUM_REGIONS-1:0] local_clock_in,
  input wire [`PRF_NUM_REGIONS*`PRF_CTRL_W-1:0] control_mode_in,
  input wire [`PRF_NUM_REGIONS*`PRF_CTRL_W-1:0] framer_ctl_in,
  output wire core_global_clock,
  output wire core_async_clear,
  output wire [`PRF_NUM_REGIONS-1:0] core_local_clock,
  output wire [`PRF_NUM_REGIONS-1:0] core_persona_reset,
  output wire [`PRF_NUM_REGIONS*`PRF_CTRL_W-1:0] core_control_mode,
  output wire [`PRF_NUM_REGIONS*`PRF_CTRL_W-1:0] core_framer_ctl,
  input wire [`PRF_NUM_REGIONS*`PRF_DATA_W-1:0] core_data_out,
  output wire [`PRF_NUM_REGIONS*`PRF_DATA_W-1:0] data_out,
  output wire [`PRF_NUM_REGIONS-1:0] region_frozen,
  output wire [`PRF_NUM_REGIONS-1:0] region_in_reset
);

  // persona reset hold in clk cycles, rounded up as a least time
  localparam integer RST_CYC =
    (`PRF_PERSONA_RESET_NS * 1000 + `PRF_CLK_PERIOD_PS - 1) / `PRF_CLK_PERIOD_PS;
  // counter constants at counter width; the cycle count is cut on purpose
  localparam [`PRF_RST_CNT_W-1:0] CNT_ZERO = {`PRF_RST_CNT_W{1'b0}};
  localparam [`PRF_RST_CNT_W-1:0] CNT_ONE = {{(`PRF_RST_CNT_W-1){1'b0}}, 1'b1};
  localparam [`PRF_RST_CNT_W-1:0] RST_CYC_W = RST_CYC[`PRF_RST_CNT_W-1:0];
  localparam [`PRF_RST_CNT_W-1:0] RST_LAST = RST_CYC_W - CNT_ONE;

  // region state codes
  localparam [1:0] ST_RUN = `PRF_ST_RUN;
  localparam [1:0] ST_FROZEN = `PRF_ST_FROZEN;
  localparam [1:0] ST_RESET = `PRF_ST_RESET;

  // a region may take six globals; only clock and async clear are used,
  // so four stay free for a persona that needs more clock domains

  // freeze edge tracking and the latched target region
  reg freeze_r;
  reg [`PRF_SEL_W-1:0] target_r;
  wire [`PRF_SEL_W-1:0] target_now;

  // global nets go straight in, never through a freeze cell
  // only clock and async clear are carried globally
  // the same reset feeds static logic as an async clear too
  // the boundary is fixed, so every persona sees these as globals
  // two globals of the six allowed per region are used
  assign core_global_clock = clk;
  assign core_async_clear = rst;

  // the select is only honoured at the freeze rising edge; a select that
  // moves mid-reconfiguration must not thaw the region being loaded
  assign target_now = freeze_r ? target_r : freeze_region_sel;

  // capture the target region when freeze arrives from user logic
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      freeze_r <= 1'b0;
      target_r <= {`PRF_SEL_W{1'b0}};
    end else begin
      freeze_r <= freeze;
      if (freeze && !freeze_r) begin
        target_r <= freeze_region_sel;
      end
    end
  end

  // one set of freeze cells and one sequencer per region
  genvar gi;
  generate
    for (gi = 0; gi < `PRF_NUM_REGIONS; gi = gi + 1) begin : g_region
      wire frz;
      wire persona_rst_src;
      reg [1:0] state_r;
      reg [1:0] state_nxt;
      reg [`PRF_RST_CNT_W-1:0] cnt_r;
      reg [`PRF_RST_CNT_W-1:0] cnt_nxt;
      reg [`PRF_DATA_W-1:0] out_r;
      reg [`PRF_DATA_W-1:0] out_nxt;
      reg frozen_r;
      reg in_reset_r;

      // region index at select width, cut on purpose from the loop index
      localparam integer REGION_IDX = gi;
      localparam [`PRF_SEL_W-1:0] REGION_ID = REGION_IDX[`PRF_SEL_W-1:0];

      // decode: freeze only the region being reconfigured
      assign frz = freeze && (target_now == REGION_ID);

      // persona reset source: held after release until the count runs out;
      // freeze forces it first, but it is low from freeze release to the next edge while state_r is still ST_FROZEN
      assign persona_rst_src = (state_r == ST_RESET);

      // control bus forced to all ones while frozen
      prf_force_high #(
        .W(`PRF_CTRL_W)
      ) u_ctrl (
        .freeze(frz),
        .src(control_mode_in[gi*`PRF_CTRL_W +: `PRF_CTRL_W]),
        .dst(core_control_mode[gi*`PRF_CTRL_W +: `PRF_CTRL_W])
      );

      // framer control, a locally routed input, frozen like the rest
      prf_force_high #(
        .W(`PRF_CTRL_W)
      ) u_framer (
        .freeze(frz),
        .src(framer_ctl_in[gi*`PRF_CTRL_W +: `PRF_CTRL_W]),
        .dst(core_framer_ctl[gi*`PRF_CTRL_W +: `PRF_CTRL_W])
      );

      // local clock parked at one while frozen freeze moving
      // mid-cycle can clip one pulse, harmless as the persona is reset after
      prf_force_high #(
        .W(1)
      ) u_lclk (
        .freeze(frz),
        .src(local_clock_in[gi]),
        .dst(core_local_clock[gi])
      );

      // persona reset is itself a non-global input, so high during freeze
      prf_force_high #(
        .W(1)
      ) u_prst (
        .freeze(frz),
        .src(persona_rst_src),
        .dst(core_persona_reset[gi])
      );

      // region sequencing: run, frozen, then persona reset after release
      always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
          ST_RUN: begin
            if (frz) begin
              state_nxt = ST_FROZEN;
            end
          end
          ST_FROZEN: begin
            if (!frz) begin
              state_nxt = ST_RESET;
              cnt_nxt = CNT_ZERO;
            end
          end
          // a new freeze during the hold goes straight back to frozen
          ST_RESET: begin
            if (frz) begin
              state_nxt = ST_FROZEN;
            end else if (cnt_r == RST_LAST) begin
              state_nxt = ST_RUN;
            end else begin
              cnt_nxt = cnt_r + CNT_ONE;
            end
          end
          default: begin
            state_nxt = ST_RUN;
          end
        endcase
      end

      // output path: clamp to the safe level while frozen when enabled;
      // with the clamp off the last pre-freeze value is held instead, which
      // keeps static logic away from a half-loaded persona either way
      always @* begin
        out_nxt = out_r;
        if (frz) begin
          if (clamp_enable) begin
            out_nxt = `PRF_OUT_SAFE;
          end
        end else begin
          out_nxt = core_data_out[gi*`PRF_DATA_W +: `PRF_DATA_W];
        end
      end

      // state, counter and held outputs; the flags are registered so
      // static logic sees clean levels, one cycle behind the freeze
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          state_r <= ST_RUN;
          cnt_r <= CNT_ZERO;
          out_r <= `PRF_OUT_RESET;
          frozen_r <= 1'b0;
          in_reset_r <= 1'b0;
        end else begin
          state_r <= state_nxt;
          cnt_r <= cnt_nxt;
          out_r <= out_nxt;
          frozen_r <= frz;
          in_reset_r <= (state_nxt == ST_RESET);
        end
      end

      // static side only ever sees the held copy
      assign data_out[gi*`PRF_DATA_W +: `PRF_DATA_W] = out_r;
      assign region_frozen[gi] = frozen_r;
      assign region_in_reset[gi] = in_reset_r;
    end
  endgenerate

endmodule

// >>> tb/prf_freeze_monitor.sv
// concurrent checks on the region freeze wrapper ports
module prf_freeze_monitor (
  input logic clk,
  input logic rst,
  input logic freeze,
  input logic [0:0] freeze_region_sel,
  input logic clamp_enable,
  input logic [1:0] local_clock_in,
  input logic [7:0] control_mode_in,
  input logic [7:0] framer_ctl_in,
  input logic core_global_clock,
  input logic core_async_clear,
  input logic [1:0] core_local_clock,
  input logic [1:0] core_persona_reset,
  input logic [7:0] core_control_mode,
  input logic [7:0] core_framer_ctl,
  input logic [31:0] core_data_out,
  input logic [31:0] data_out,
  input logic [1:0] region_frozen,
  input logic [1:0] region_in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // sampled just before the rising edge, so a global clock forced high shows
  a_global_clock_pass: assert property (!core_global_clock && !core_async_clear)
    else $error("global clock or clear not passed through");
  a_ctrl_frozen_high: assert property (freeze && region_frozen[0] |->
    core_control_mode[3:0] == 4'hf && core_framer_ctl[3:0] == 4'hf)
    else $error("frozen control not all ones");
  a_local_clock_held: assert property (freeze && region_frozen[0] |->
    core_local_clock[0] && core_persona_reset[0])
    else $error("frozen local clock not high");
  a_idle_pass_through: assert property (!freeze |-> core_control_mode == control_mode_in &&
    core_framer_ctl == framer_ctl_in && core_local_clock == local_clock_in)
    else $error("inputs altered while not frozen");
  a_other_region_runs: assert property (freeze && region_frozen[0] |->
    core_control_mode[7:4] == control_mode_in[7:4] && core_local_clock[1] == local_clock_in[1])
    else $error("unselected region disturbed");
  a_frozen_flag_set: assert property ($rose(freeze) && freeze_region_sel == 1'b0 |=> region_frozen == 2'h1)
    else $error("frozen flag wrong");
  a_clamp_to_zero: assert property (freeze && region_frozen[0] && clamp_enable |=> data_out[15:0] == 16'h0000)
    else $error("output not clamped");
  a_output_held: assert property (freeze && region_frozen[0] && !clamp_enable |=> $stable(data_out[15:0]))
    else $error("output not held");
  a_data_follows: assert property (!freeze |=> data_out == $past(core_data_out))
    else $error("output not following core");
  a_persona_reset_len: assert property ($fell(freeze) && region_frozen[0] |=>
    region_in_reset[0] [*8] ##1 region_in_reset[0] [*8] ##1 !region_in_reset[0])
    else $error("persona reset length wrong");
endmodule
bind prf_freeze_wrapper prf_freeze_monitor i_mon (.*);

// >>> tb/prf_core_model.sv
// behavioural reconfigurable core: outputs change every cycle
module prf_core_model (
  input logic clk,
  input logic [1:0] persona_reset,
  input logic [7:0] ctrl,
  output logic [31:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  // free count keeps outputs moving, so a stuck hold or clamp shows
  always @(posedge clk) cnt_r <= cnt_r + 8'h01;
  assign dout = {ctrl[7:4], 3'h0, persona_reset[1], cnt_r, ctrl[3:0], 3'h0, persona_reset[0], cnt_r};
endmodule

// >>> tb/tb.sv
// self-checking bench for the region freeze wrapper
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, freeze = 1'b0, clamp_enable = 1'b0;
  logic [0:0] freeze_region_sel = 1'b0;
  logic [1:0] local_clock_in = 2'h0;
  logic [7:0] control_mode_in = 8'h00, framer_ctl_in = 8'h00;
  wire core_global_clock, core_async_clear;
  wire [1:0] core_local_clock, core_persona_reset, region_frozen, region_in_reset;
  wire [7:0] core_control_mode, core_framer_ctl;
  wire [31:0] core_data_out, data_out;
  int miscompares = 0, checks_done = 0;
  prf_freeze_wrapper i_dut (.*);
  prf_core_model i_core (.clk(clk), .persona_reset(core_persona_reset), .ctrl(core_control_mode),
    .dout(core_data_out));
  // 250 MHz clock
  always #2 clk = ~clk;
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_idle;
    step;
    control_mode_in = 8'h5a;
    framer_ctl_in = 8'h3c;
    local_clock_in = 2'h2;
    #0.5;
    chk(core_control_mode, 8'h5a);
    chk({core_framer_ctl, core_local_clock}, {8'h3c, 2'h2});
    chk({core_global_clock, core_async_clear}, 2'h2);
    $display("idle test done");
  endtask
  // freeze one region, hold, retarget attempt, release, time the persona reset
  task automatic t_freeze(input int r, input logic cl);
    logic [31:0] held;
    int n;
    step;
    freeze_region_sel = r[0];
    clamp_enable = cl;
    freeze = 1'b1;
    local_clock_in = 2'h0;
    control_mode_in = 8'h00;
    #1;
    chk(core_control_mode[4*r+:4], 4'hf);
    chk(core_control_mode[4*(1-r)+:4], 4'h0);
    chk({core_local_clock, core_persona_reset[r]}, {2'h1 << r, 1'b1});
    #1;
    chk({core_global_clock, core_async_clear}, 2'h0);
    repeat (3) step;
    chk(region_frozen, 2'h1 << r);
    held = data_out;
    freeze_region_sel = ~freeze_region_sel;
    step;
    chk(core_framer_ctl[4*r+:4], 4'hf);
    chk(data_out[16*r+:16], cl ? 16'h0000 : held[16*r+:16]);
    freeze = 1'b0;
    #1;
    chk(core_control_mode, 8'h00);
    n = 0;
    step;
    // waits on status flags only, never on region output levels
    while (region_in_reset[r] === 1'b1 && n < 40) begin
      chk(core_persona_reset[r], 1'b1);
      n++;
      step;
    end
    chk(n, 16);
    chk(core_persona_reset[r], 1'b0);
    $display("freeze test done region %0d clamp %0d", r, cl);
  endtask
  // reset in mid-run clears the registered outputs
  task automatic t_reset;
    step;
    freeze = 1'b1;
    repeat (3) step;
    freeze = 1'b0;
    rst = 1'b1;
    #1;
    chk(region_frozen, 2'h0);
    chk(data_out, 32'h0);
    step;
    rst = 1'b0;
    step;
    chk(region_in_reset, 2'h0);
    $display("reset test done");
  endtask
  // watchdog cuts a hang short
  initial begin
    #20000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_idle;
    for (int r = 0; r < 2; r++) begin
      t_freeze(r, 1'b1);
      t_freeze(r, 1'b0);
    end
    t_reset;
    t_idle;
    stop_test;
  end
endmodule
